// [inc/gsw_pkg.sv]
// Constants, register map and shared types of the playback gain-swap control.
// Assumes one audio processing clock with frame and Fs*8 / Fs*16 tick strobes.
package gsw_pkg;

    localparam int SAMPLE_W = 24;
    localparam int AVG_FRAC = 16;
    localparam int AVG_W = SAMPLE_W + AVG_FRAC;
    localparam int NCH = 2;
    localparam int UNIT_W = 7;
    localparam int ATT_W = 7;
    localparam int CNT_W = 8;
    localparam int SHIFT_W = 5;

    // Register offsets
    localparam logic [7:0] ADDR_TRIGGER = 8'h54;
    localparam logic [7:0] ADDR_ENABLE = 8'h55;
    localparam logic [7:0] ADDR_RATES = 8'h56;
    localparam logic [7:0] ADDR_DELAY = 8'h57;
    localparam logic [7:0] ADDR_DELAY_FAST = 8'h58;
    localparam logic [7:0] ADDR_DELAY_VOICE = 8'h59;
    localparam logic [7:0] ADDR_LEVELS = 8'h5A;
    localparam logic [7:0] ADDR_RAMP = 8'h5B;

    // Reset values
    localparam logic [7:0] RST_TRIGGER = 8'h24;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_RATES = 8'h50;
    localparam logic [7:0] RST_DELAY = 8'hA3;
    localparam logic [7:0] RST_DELAY_FAST = 8'h31;
    localparam logic [7:0] RST_DELAY_VOICE = 8'h11;
    localparam logic [7:0] RST_LEVELS = 8'h01;
    localparam logic [7:0] RST_RAMP = 8'h74;

    // Writable bits; reserved bits read zero
    localparam logic [7:0] MASK_TRIGGER = 8'h3F;
    localparam logic [7:0] MASK_ENABLE = 8'h03;
    localparam logic [7:0] MASK_RATES = 8'h77;
    localparam logic [7:0] MASK_DELAY = 8'hFF;
    localparam logic [7:0] MASK_DELAY_VOICE = 8'h7F;
    localparam logic [7:0] MASK_LEVELS = 8'hF7;
    localparam logic [7:0] MASK_RAMP = 8'h7F;

    // Field positions
    localparam int FALL_LSB = 4;
    localparam int SIGLVL_LSB = 4;
    localparam int SUBR_BIT = 6;
    localparam int RAMP_BIT = 5;
    localparam int STEPS_W = 5;
    localparam int TRIG_W = 6;

    // Gain units are 0.5 dB; one swap step is 1.5 dB; 6 dB is four steps
    localparam logic [UNIT_W-1:0] UNITS_PER_STEP = 7'h03;
    localparam logic [UNIT_W-1:0] UNITS_SUB = 7'h01;
    localparam logic [ATT_W-1:0] ATT_MAX = 7'h7F;
    localparam logic [SHIFT_W-1:0] RISE_BASE_SHIFT = 5'h00;
    localparam logic [SHIFT_W-1:0] FALL_BASE_SHIFT = 5'h02;

    typedef struct packed {
        logic [7:0] trigger;
        logic [7:0] enable;
        logic [7:0] rates;
        logic [7:0] delay;
        logic [7:0] delay_fast;
        logic [7:0] delay_voice;
        logic [7:0] levels;
        logic [7:0] ramp;
    } gsw_regs_t;

    typedef struct packed {
        logic [UNIT_W-1:0] dig;
        logic [UNIT_W-1:0] ana;
    } gsw_gain_t;

    typedef enum logic [0:0] {
        PH_IDLE = 1'b0,
        PH_WAIT = 1'b1
    } gsw_phase_t;

    typedef struct packed {
        gsw_phase_t phase;
        logic [UNIT_W-1:0] dig;
        logic [UNIT_W-1:0] ana;
        logic [CNT_W-1:0] cnt;
    } gsw_chan_t;

    typedef struct packed {
        logic [AVG_W-1:0] avg;
    } gsw_est_t;

    function automatic logic [SAMPLE_W-1:0] mag(input logic signed [SAMPLE_W-1:0] x);
        mag = x[SAMPLE_W-1] ? SAMPLE_W'(-x) : SAMPLE_W'(x);
    endfunction

    // Code 0 and 1 track the input directly; 2..7 give 1/16 .. 1/16384
    function automatic logic [SHIFT_W-1:0] rise_shift(input logic [2:0] code);
        rise_shift = (code <= 3'h1) ? RISE_BASE_SHIFT : SHIFT_W'({code, 1'b0});
    endfunction

    // 1/4 .. 1/65536, each code another divide by four
    function automatic logic [SHIFT_W-1:0] fall_shift(input logic [2:0] code);
        fall_shift = FALL_BASE_SHIFT + SHIFT_W'({code, 1'b0});
    endfunction

endpackage

// [rtl/gsw_level_est.sv]
// Leaky-integrator amplitude estimator for one playback channel.
// Assumes sample_vld is a one-cycle strobe per frame on the same clock.
`timescale 1ns/1ns
`default_nettype none
module gsw_level_est (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sample_vld,
    input wire logic signed [gsw_pkg::SAMPLE_W-1:0] sample,
    input wire logic [2:0] rise_code,
    input wire logic [2:0] fall_code,
    output logic [gsw_pkg::SAMPLE_W-1:0] level
);
    import gsw_pkg::*;

    gsw_est_t s_q, s_d;
    logic [AVG_W-1:0] x;

    always_comb begin
        s_d = s_q;
        x = {mag(sample), AVG_FRAC'(0)};
        if (sample_vld) begin
            if (x > s_q.avg) begin
                s_d.avg = s_q.avg + ((x - s_q.avg) >> rise_shift(rise_code));
            end else begin
                s_d.avg = s_q.avg - ((s_q.avg - x) >> fall_shift(fall_code));
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign level = s_q.avg[AVG_W-1:AVG_FRAC];
endmodule
`default_nettype wire

// [rtl/gsw_ctrl.sv]
// Gain-swap control: registers, level decode, step ramp and delayed analogue update.
// Assumes samples, frame strobe and rate ticks come from logic on clk.
`timescale 1ns/1ns
`default_nettype none
//
// Behaviour
// - Trigger code counts 1.5 dB of attenuation per step, 0 dB to -94.5 dB.
// - At or below the trigger level every permitted swap step is applied.
// - Enable bit 0 gates the left channel, bit 1 the right.
// - Falling input pulls the average by 1/4 to 1/65536, per 3-bit code.
// - Rising input pulls the average by 1/1 or 1/16 to 1/16384.
// - Analogue update lags digital by an 8-bit count of Fs*8 periods, in voice mode a 7-bit count of Fs*16 periods.
// - Delay counting starts at the frame where digital gain changes.
// - Total swap limited to programmed 1.5 dB steps, even with sub-ranging.
// - Input above anti-clip level (6 dB steps) drops all swap steps at once.
module gsw_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic frame_start,
    input wire logic [gsw_pkg::NCH-1:0][gsw_pkg::SAMPLE_W-1:0] sample,
    input wire logic tick_fs8,
    input wire logic tick_fs16,
    input wire logic fast_rate,
    input wire logic voice_mode,
    output gsw_pkg::gsw_gain_t [gsw_pkg::NCH-1:0] gain
);
    import gsw_pkg::*;

    typedef struct packed {
        gsw_regs_t regs;
        logic [7:0] rdata;
        gsw_chan_t [NCH-1:0] ch;
    } gsw_state_t;

    gsw_state_t s_q, s_d;
    logic [NCH-1:0][SAMPLE_W-1:0] level;
    logic [ATT_W-1:0] att;
    logic [ATT_W-1:0] trig;
    logic [ATT_W-1:0] sig_att;
    logic [ATT_W-1:0] clip_att;
    logic [ATT_W-1:0] deficit;
    logic [STEPS_W-1:0] steps;
    logic [UNIT_W-1:0] max_units;
    logic [UNIT_W-1:0] target;
    logic [UNIT_W-1:0] stride;
    logic [CNT_W-1:0] delay_sel;
    logic tick;
    logic clip;

    // Attenuation below full scale in 1.5 dB steps: 6 dB per octave plus two mantissa bits
    function automatic logic [ATT_W-1:0] atten(input logic [SAMPLE_W-1:0] lv);
        logic [ATT_W-1:0] a;
        logic found;
        a = ATT_MAX;
        found = 1'b0;
        for (int i = SAMPLE_W - 1; i >= 2; i--) begin
            if (!found && lv[i]) begin
                found = 1'b1;
                a = ATT_W'((SAMPLE_W - 1 - i) * 4 + 3 - int'(lv[i-1 -: 2]));
            end
        end
        atten = a;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_est
            gsw_level_est u_est (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .sample_vld(frame_start),
                .sample(sample[g]),
                .rise_code(s_q.regs.rates[2:0]),
                .fall_code(s_q.regs.rates[FALL_LSB+2:FALL_LSB]),
                .level(level[g])
            );
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        att = '0;
        deficit = '0;
        target = '0;
        clip = 1'b0;
        trig = ATT_W'(s_q.regs.trigger[TRIG_W-1:0]);
        sig_att = ATT_W'({s_q.regs.levels[SIGLVL_LSB+3:SIGLVL_LSB], 2'b00});
        clip_att = ATT_W'({s_q.regs.levels[2:0], 2'b00});
        steps = s_q.regs.ramp[STEPS_W-1:0];
        max_units = UNIT_W'(steps) * UNITS_PER_STEP;
        stride = s_q.regs.ramp[SUBR_BIT] ? UNITS_SUB : UNITS_PER_STEP;

        // Register port
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_TRIGGER: s_d.regs.trigger = reg_wdata & MASK_TRIGGER;
                ADDR_ENABLE: s_d.regs.enable = reg_wdata & MASK_ENABLE;
                ADDR_RATES: s_d.regs.rates = reg_wdata & MASK_RATES;
                ADDR_DELAY: s_d.regs.delay = reg_wdata & MASK_DELAY;
                ADDR_DELAY_FAST: s_d.regs.delay_fast = reg_wdata & MASK_DELAY;
                ADDR_DELAY_VOICE: s_d.regs.delay_voice = reg_wdata & MASK_DELAY_VOICE;
                ADDR_LEVELS: s_d.regs.levels = reg_wdata & MASK_LEVELS;
                ADDR_RAMP: s_d.regs.ramp = reg_wdata & MASK_RAMP;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TRIGGER: s_d.rdata = s_q.regs.trigger;
                ADDR_ENABLE: s_d.rdata = s_q.regs.enable;
                ADDR_RATES: s_d.rdata = s_q.regs.rates;
                ADDR_DELAY: s_d.rdata = s_q.regs.delay;
                ADDR_DELAY_FAST: s_d.rdata = s_q.regs.delay_fast;
                ADDR_DELAY_VOICE: s_d.rdata = s_q.regs.delay_voice;
                ADDR_LEVELS: s_d.rdata = s_q.regs.levels;
                ADDR_RAMP: s_d.rdata = s_q.regs.ramp;
                default: s_d.rdata = '0;
            endcase
        end

        // Delay set and its tick follow the datapath rate mode
        if (voice_mode) begin
            delay_sel = s_q.regs.delay_voice;
            tick = tick_fs16;
        end else if (fast_rate) begin
            delay_sel = s_q.regs.delay_fast;
            tick = tick_fs8;
        end else begin
            delay_sel = s_q.regs.delay;
            tick = tick_fs8;
        end

        for (int c = 0; c < NCH; c++) begin
            att = atten(level[c]);
            clip = s_q.ch[c].dig != '0 && att < clip_att;

            // Swap amount wanted from the estimated level
            if (!s_q.regs.enable[c]) begin
                target = '0;
            end else if (att >= trig) begin
                target = max_units;
            end else begin
                deficit = trig - att;
                target = (deficit >= ATT_W'(steps)) ? '0
                       : UNIT_W'(steps - STEPS_W'(deficit)) * UNITS_PER_STEP;
                if (att < sig_att && target > s_q.ch[c].dig) begin
                    target = s_q.ch[c].dig;
                end
            end

            // Digital gain moves only at a frame start
            if (frame_start && clip) begin
                s_d.ch[c].dig = '0;
                s_d.ch[c].phase = PH_WAIT;
                s_d.ch[c].cnt = delay_sel;
            end else if (frame_start && s_q.ch[c].phase == PH_IDLE
                         && target != s_q.ch[c].dig) begin
                if (!s_q.regs.ramp[RAMP_BIT]) begin
                    s_d.ch[c].dig = target;
                end else if (target > s_q.ch[c].dig) begin
                    s_d.ch[c].dig = (target - s_q.ch[c].dig > stride)
                                  ? s_q.ch[c].dig + stride : target;
                end else begin
                    s_d.ch[c].dig = (s_q.ch[c].dig - target > stride)
                                  ? s_q.ch[c].dig - stride : target;
                end
                s_d.ch[c].phase = PH_WAIT;
                s_d.ch[c].cnt = delay_sel;
            end else begin
                unique case (s_q.ch[c].phase)
                    PH_IDLE: ;
                    PH_WAIT: begin
                        if (s_q.ch[c].cnt == '0) begin
                            s_d.ch[c].ana = s_q.ch[c].dig;
                            s_d.ch[c].phase = PH_IDLE;
                        end else if (tick) begin
                            s_d.ch[c].cnt = s_q.ch[c].cnt - 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.regs.trigger <= RST_TRIGGER;
            s_q.regs.enable <= RST_ENABLE;
            s_q.regs.rates <= RST_RATES;
            s_q.regs.delay <= RST_DELAY;
            s_q.regs.delay_fast <= RST_DELAY_FAST;
            s_q.regs.delay_voice <= RST_DELAY_VOICE;
            s_q.regs.levels <= RST_LEVELS;
            s_q.regs.ramp <= RST_RAMP;
            s_q.rdata <= '0;
            s_q.ch <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            gain[c].dig = s_q.ch[c].dig;
            gain[c].ana = s_q.ch[c].ana;
        end
    end
endmodule
`default_nettype wire

// [bench/gsw_ctrl_chk.sv]
// Port-level checker for the gain-swap control, bound to gsw_ctrl.
// Assumes register writes only through reg_wr; tracks the fields it needs.
`timescale 1ns/1ns
`default_nettype none
module gsw_ctrl_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic frame_start,
    input wire logic tick_fs8,
    input wire logic fast_rate,
    input wire logic voice_mode,
    input wire gsw_pkg::gsw_gain_t [gsw_pkg::NCH-1:0] gain
);
    import gsw_pkg::*;
    logic [7:0] en_q;
    logic [7:0] delay_q;
    logic [7:0] ramp_q;
    logic [7:0] ticks_q;
    logic [UNIT_W-1:0] dig_q;
    // Shadow of the fields and Fs*8 ticks since the last digital change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_q <= RST_ENABLE;
            delay_q <= RST_DELAY;
            ramp_q <= RST_RAMP;
            ticks_q <= '0;
            dig_q <= '0;
        end else if (ce) begin
            if (reg_wr && reg_addr == ADDR_ENABLE) en_q <= reg_wdata & MASK_ENABLE;
            if (reg_wr && reg_addr == ADDR_DELAY) delay_q <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_RAMP) ramp_q <= reg_wdata & MASK_RAMP;
            dig_q <= gain[0].dig;
            if (gain[0].dig != dig_q) ticks_q <= '0;
            else if (tick_fs8) ticks_q <= ticks_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_dig_step;
        $changed(gain[0].dig) && gain[0].dig != gain[0].ana;
    endsequence
    property p_dig_on_frame;
        $changed(gain[0].dig) |-> $past(frame_start) && $past(ce);
    endproperty
    property p_ana_follows;
        $changed(gain[0].ana) |-> gain[0].ana == gain[0].dig;
    endproperty
    property p_ana_delay;
        $changed(gain[0].ana) && !fast_rate && !voice_mode |-> ticks_q == delay_q;
    endproperty
    property p_no_early;
        s_dig_step ##0 (delay_q != 8'h00) |=> $stable(gain[0].ana);
    endproperty
    property p_en_gate;
        gain[1].dig > $past(gain[1].dig) |-> $past(en_q[1]);
    endproperty
    property p_subr_step;
        gain[0].dig > $past(gain[0].dig) && $past(ramp_q[6:5]) == 2'b11
            |-> gain[0].dig == $past(gain[0].dig) + 7'h01;
    endproperty
    property p_step_limit;
        gain[0].dig <= 7'(ramp_q[4:0]) * UNITS_PER_STEP;
    endproperty
    property p_refuse_wait;
        gain[0].dig != gain[0].ana |=> $stable(gain[0].dig) || gain[0].dig == '0;
    endproperty
    a_dig_on_frame: assert property (p_dig_on_frame) else $error("dig off frame");
    a_ana_follows: assert property (p_ana_follows) else $error("ana not dig");
    a_ana_delay: assert property (p_ana_delay) else $error("ana delay count");
    a_no_early: assert property (p_no_early) else $error("ana too early");
    a_en_gate: assert property (p_en_gate) else $error("right rose while off");
    a_subr_step: assert property (p_subr_step) else $error("sub step not 1");
    a_step_limit: assert property (p_step_limit) else $error("over step limit");
    a_refuse_wait: assert property (p_refuse_wait) else $error("step while waiting");
endmodule
bind gsw_ctrl gsw_ctrl_chk u_gsw_ctrl_chk (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .frame_start(frame_start), .tick_fs8(tick_fs8),
    .fast_rate(fast_rate), .voice_mode(voice_mode), .gain(gain));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the gain-swap control.
// Assumes frames every 32 cycles with eight Fs*8 ticks, made here.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import gsw_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} gsw_row_t;
    logic clk, rstn, ce, reg_wr, reg_rd, tick_fs16, fast_rate, voice_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic frame_start = 1'b0;
    logic frames_on = 1'b0;
    logic tick_fs8 = 1'b0;
    logic [4:0] phase = '0;
    logic [NCH-1:0][SAMPLE_W-1:0] sample;
    gsw_gain_t [NCH-1:0] gain;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] rstv [8] = '{RST_TRIGGER, RST_ENABLE, RST_RATES, RST_DELAY, RST_DELAY_FAST,
        RST_DELAY_VOICE, RST_LEVELS, RST_RAMP};
    // Masked write rows, then the working set-up
    gsw_row_t rows [15] = '{'{8'h54, 8'hFF, 8'h3F}, '{8'h55, 8'hFF, 8'h03},
        '{8'h56, 8'hFF, 8'h77}, '{8'h57, 8'hFF, 8'hFF}, '{8'h58, 8'hFF, 8'hFF},
        '{8'h59, 8'hFF, 8'h7F}, '{8'h5A, 8'hFF, 8'hF7}, '{8'h5B, 8'hFF, 8'h7F},
        '{8'h60, 8'hFF, 8'h00}, '{8'h54, 8'h3F, 8'h3F}, '{8'h55, 8'h01, 8'h01},
        '{8'h56, 8'h01, 8'h01}, '{8'h57, 8'h03, 8'h03}, '{8'h5A, 8'h01, 8'h01},
        '{8'h5B, 8'h14, 8'h14}};
    gsw_ctrl u_gsw_ctrl (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .sample(sample), .tick_fs8(tick_fs8), .tick_fs16(tick_fs16),
        .fast_rate(fast_rate), .voice_mode(voice_mode), .gain(gain));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Ticks kept clear of the frame cycle and the one after it
    always @(negedge clk) begin
        phase <= phase + 5'h01;
        frame_start <= frames_on && (phase == 5'h1F);
        tick_fs8 <= (phase[1:0] == 2'h2);
    end
    task automatic conclude();
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic frames(input int n);
        repeat (n) @(posedge frame_start);
        @(negedge clk);
    endtask
    // Anti-clip drop, then ramp back up one step per frame
    task automatic ramp(input logic [7:0] ctl, input logic [6:0] step);
        logic [6:0] prev;
        wr(ADDR_RAMP, ctl);
        sample[0] = 24'h800000;
        frames(3);
        check({1'b0, gain[0].dig}, 8'h00);
        sample[0] = '0;
        prev = gain[0].dig;
        repeat (130) begin
            frames(1);
            if (gain[0].dig !== prev) check({1'b0, gain[0].dig - prev}, {1'b0, step});
            prev = gain[0].dig;
        end
        check({1'b0, gain[0].dig}, 8'h3C);
    endtask
    initial begin
        #(40 * 30000);
        n_mismatch++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        {rstn, reg_wr, reg_rd, tick_fs16, fast_rate, voice_mode} = '0;
        {ce, reg_addr, reg_wdata, sample} = {1'b1, 16'h0000, 48'h0};
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'h54 + 8'(i), d);
            check(d, rstv[i]);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, d);
            check(d, rows[i].e);
        end
        // No frames while the mask rows leave both channels enabled
        frames_on = 1'b1;
        sample[0] = 24'h000100;
        frames(4);
        check({1'b0, gain[0].dig}, 8'h3C);
        sample[0] = 24'h000140;
        frames(4);
        check({1'b0, gain[0].dig}, 8'h39);
        check({1'b0, gain[0].ana}, 8'h39);
        check({1'b0, gain[1].dig}, 8'h00);
        ce = 1'b0;
        wr(ADDR_ENABLE, 8'h00);
        ce = 1'b1;
        rd(ADDR_ENABLE, d);
        check(d, 8'h01);
        ramp(8'h74, 7'h01);
        ramp(8'h34, 7'h03);
        // Right channel, fast-rate delay of five Fs*8 ticks
        fast_rate = 1'b1;
        wr(ADDR_DELAY_FAST, 8'h05);
        wr(ADDR_ENABLE, 8'h03);
        frames(1);
        check({1'b0, gain[1].dig}, 8'h03);
        repeat (16) @(negedge clk);
        check({1'b0, gain[1].ana}, 8'h00);
        repeat (8) @(negedge clk);
        check({1'b0, gain[1].ana}, 8'h03);
        fast_rate = 1'b0;
        rstn = 1'b0;
        @(negedge clk);
        check({1'b0, gain[0].dig}, 8'h00);
        rstn = 1'b1;
        rd(ADDR_DELAY, d);
        check(d, 8'hA3);
        conclude();
    end
endmodule
`default_nettype wire
